/* File: hw/lsrc_defines.svh */
// Offsets, field positions, reset values and timing constants of the light sensor control block
`ifndef LSRC_DEFINES_SVH
`define LSRC_DEFINES_SVH

// ----------------------------------------------------------------
// Serial bus identity
// ----------------------------------------------------------------
`define LSRC_BUS_ADDR       7'h44

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LSRC_OFS_OPCTL      8'h00
`define LSRC_OFS_SETUP      8'h01
`define LSRC_OFS_RES_LO     8'h02
`define LSRC_OFS_RES_HI     8'h03
`define LSRC_OFS_IDENT      8'h0f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LSRC_MODE_MSB       7
`define LSRC_MODE_LSB       5
`define LSRC_RES_MSB        3
`define LSRC_RES_LSB        2
`define LSRC_SCALE_MSB      1
`define LSRC_SCALE_LSB      0
`define LSRC_BROWNOUT_FLAG_BIT       7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSRC_OPCTL_RST      3'h0
`define LSRC_SETUP_RST      4'h0
`define LSRC_RESULT_RST     16'h0000
`define LSRC_BROWNOUT_FLAG_RST       1'b1

// ----------------------------------------------------------------
// Result widths per resolution code
// ----------------------------------------------------------------
`define LSRC_BITS_R16       5'd16
`define LSRC_BITS_R12       5'd12
`define LSRC_BITS_R8        5'd8
`define LSRC_BITS_R4        5'd4

// ----------------------------------------------------------------
// Full-scale illuminance per range code, in lux
// ----------------------------------------------------------------
`define LSRC_FS_LUX0        16'd1000
`define LSRC_FS_LUX1        16'd4000
`define LSRC_FS_LUX2        16'd16000
`define LSRC_FS_LUX3        16'd64000

// ----------------------------------------------------------------
// Timing: clock period and integration times
// ----------------------------------------------------------------
`define LSRC_CLK_NS         8.0
`define LSRC_TINT16_MS      105.0
`define LSRC_TINT12_MS      5.6
`define LSRC_TINT8_MS       0.352
`define LSRC_TINT4_MS       0.022
`define LSRC_MS2CYC(ms)     ($rtoi((ms) * 1000000.0 / `LSRC_CLK_NS))
`define LSRC_CYC_R4         `LSRC_MS2CYC(`LSRC_TINT4_MS)

`endif

/* File: hw/lsrc_pkg.sv */
// Types shared by the light sensor control block
package lsrc_pkg;

    // Operation mode codes of the first control register
    typedef enum logic [2:0] {
        lsrc_mode_off      = 3'b000,
        lsrc_mode_once_vis = 3'b001,
        lsrc_mode_once_ir  = 3'b010,
        lsrc_mode_cont_vis = 3'b101,
        lsrc_mode_cont_ir  = 3'b110
    } lsrc_mode_t;

    // Resolution codes of the second control register
    typedef enum logic [1:0] {
        lsrc_res_16 = 2'b00,
        lsrc_res_12 = 2'b01,
        lsrc_res_8  = 2'b10,
        lsrc_res_4  = 2'b11
    } lsrc_res_t;

    // Serial bus engine states
    typedef enum logic [2:0] {
        lsrc_bus_idle,
        lsrc_bus_dev,
        lsrc_bus_reg,
        lsrc_bus_wr,
        lsrc_bus_ack,
        lsrc_bus_rd,
        lsrc_bus_rack
    } lsrc_bus_st_t;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        lsrc_conv_off,
        lsrc_conv_run,
        lsrc_conv_hold
    } lsrc_conv_st_t;

endpackage

/* File: hw/lsrc_conv_if.sv */
// Handshake between the conversion sequencer and the integration timer
`timescale 1ns/100ps
interface lsrc_conv_if;
    import lsrc_pkg::*;

    logic      start;
    logic      abort;
    lsrc_res_t res_sel;
    logic      done;

    modport ctl (output start, output abort, output res_sel, input done);
    modport tmr (input start, input abort, input res_sel, output done);
endinterface

/* File: hw/lsrc_conv_timer.sv */
// Integration timer: counts the integration period chosen by the resolution
`timescale 1ns/100ps
`include "lsrc_defines.svh"
module lsrc_conv_timer
    import lsrc_pkg::*;
#(
    parameter int CYC_R16 = `LSRC_MS2CYC(`LSRC_TINT16_MS),
    parameter int CYC_R12 = `LSRC_MS2CYC(`LSRC_TINT12_MS),
    parameter int CYC_R8  = `LSRC_MS2CYC(`LSRC_TINT8_MS)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Sequencer side
    lsrc_conv_if.tmr conv
);

    logic [23:0] count;
    logic [23:0] next_count;
    logic        run;
    logic        next_run;
    logic        done_q;
    logic        next_done;
    logic [23:0] limit;

    // ----------------------------------------------------------------
    // Period select and count
    // ----------------------------------------------------------------
    always_comb begin
        case (conv.res_sel)
            lsrc_res_16: limit = 24'(CYC_R16);
            lsrc_res_12: limit = 24'(CYC_R12);
            lsrc_res_8:  limit = 24'(CYC_R8);
            default:     limit = 24'(`LSRC_CYC_R4);
        endcase
        next_count = count;
        next_run   = run;
        next_done  = 1'b0;
        // Start wins over abort so a rewrite restarts cleanly
        if (conv.start) begin
            next_run   = 1'b1;
            next_count = limit - 24'd1;
        end else if (conv.abort) begin
            next_run = 1'b0;
        end else if (run) begin
            if (count == 24'd0) begin
                next_run  = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count - 24'd1;
            end
        end
    end

    // Registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count  <= 24'd0;
            run    <= 1'b0;
            done_q <= 1'b0;
        end else begin
            count  <= next_count;
            run    <= next_run;
            done_q <= next_done;
        end
    end

    assign conv.done = done_q;

endmodule

/* File: hw/lsrc_top.sv */
// Light sensor register control: serial bus slave, registers and conversion sequencer
//
// What this block does
// - Every register is reached only through the two-wire serial bus.
// - Mode field sits in bits 7:5, resets to zero, starting powered down.
// - Modes: off, visible once, infrared once, visible continuous, infrared continuous.
// - Second register resets to zero; resolution bits 3:2, range bits 1:0.
// - Range code selects 1000, 4000, 16000 or 64000 lux full scale.
// - Resolution code selects 16, 12, 8 or 4 bit conversions.
// - Integration period follows resolution: 105, 5.6, 0.352, 0.022 ms.
// - Result held in read-only bytes at 0x02 and 0x03, zero after reset.
// - Result is right-aligned from bit zero for every resolution.
// - Both result bytes update at the end of every completed conversion.
// - Identity register at 0x0F returns a fixed read-only code in bits 5:3.
// - Identity bit 7 is a brownout flag reading one after power-up.
// - Host clears brownout with a write; it stays zero until next power-up.
`timescale 1ns/100ps
`include "lsrc_defines.svh"
module lsrc_top
    import lsrc_pkg::*;
#(
    parameter int         CYC_R16   = `LSRC_MS2CYC(`LSRC_TINT16_MS),
    parameter int         CYC_R12   = `LSRC_MS2CYC(`LSRC_TINT12_MS),
    parameter int         CYC_R8    = `LSRC_MS2CYC(`LSRC_TINT8_MS),
    parameter logic [2:0] DEV_CODE  = 3'h2  // Arbitrary device code value
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Two-wire serial bus, open drain data
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe,
    // Converter front end
    input  wire logic [15:0] adc_visible_raw,
    input  wire logic [15:0] adc_infrared_raw,
    output var  logic        conv_active,
    output var  logic        infrared_select,
    output var  logic [1:0]  full_scale_selection,
    output var  logic [15:0] full_scale_lux
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    lsrc_conv_if conv ();

    logic          scl_q;
    logic          sda_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_ev;
    logic          stop_ev;

    lsrc_bus_st_t  bus_st;
    lsrc_bus_st_t  next_bus_st;
    lsrc_bus_st_t  ret_st;
    lsrc_bus_st_t  next_ret_st;
    logic [7:0]    shreg;
    logic [7:0]    next_shreg;
    logic [3:0]    bit_cnt;
    logic [3:0]    next_bit_cnt;
    logic [7:0]    ptr;
    logic [7:0]    next_ptr;
    logic          next_sda_oe;
    logic          wr_en;
    logic [7:0]    wr_data;

    logic [2:0]    mode;
    logic [2:0]    next_mode;
    logic [3:0]    setup;
    logic [3:0]    next_setup;
    logic [15:0]   result;
    logic [15:0]   next_result;
    logic          brownout_flag;
    logic          next_brownout_flag;
    logic          mode_wr;
    logic          setup_wr;

    lsrc_conv_st_t conv_st;
    lsrc_conv_st_t next_conv_st;
    logic          ir_chan;
    logic          next_ir_chan;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Read mux; unmapped and reserved bits read as zero
    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == `LSRC_OFS_OPCTL) begin
            d[`LSRC_MODE_MSB:`LSRC_MODE_LSB] = mode;
        end else if (a == `LSRC_OFS_SETUP) begin
            d[`LSRC_RES_MSB:`LSRC_SCALE_LSB] = setup;
        end else if (a == `LSRC_OFS_RES_LO) begin
            d = result[7:0];
        end else if (a == `LSRC_OFS_RES_HI) begin
            d = result[15:8];
        end else if (a == `LSRC_OFS_IDENT) begin
            d[5:3]            = DEV_CODE;
            d[`LSRC_BROWNOUT_FLAG_BIT] = brownout_flag;
        end
        return d;
    endfunction

    // Pointer walks 0,1,2,3,0x0F and rolls back to 0
    function automatic logic [7:0] ptr_inc(input logic [7:0] a);
        logic [7:0] n;
        n = a + 8'h01;
        if (a == `LSRC_OFS_RES_HI) begin
            n = `LSRC_OFS_IDENT;
        end else if (a >= `LSRC_OFS_IDENT) begin
            n = `LSRC_OFS_OPCTL;
        end
        return n;
    endfunction

    // Result width for the resolution code
    function automatic logic [4:0] res_bits(input logic [1:0] r);
        logic [4:0] b;
        case (lsrc_res_t'(r))
            lsrc_res_16: b = `LSRC_BITS_R16;
            lsrc_res_12: b = `LSRC_BITS_R12;
            lsrc_res_8:  b = `LSRC_BITS_R8;
            default:     b = `LSRC_BITS_R4;
        endcase
        return b;
    endfunction

    // ----------------------------------------------------------------
    // Bus line events
    // ----------------------------------------------------------------
    // Lines are taken as already synchronous; one stage of history finds edges
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign start_ev = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_ev  = scl_in & scl_q & ~sda_q & sda_in;
    assign wr_data  = shreg;

    // ----------------------------------------------------------------
    // Serial bus engine
    // ----------------------------------------------------------------
    always_comb begin
        next_bus_st  = bus_st;
        next_ret_st  = ret_st;
        next_shreg   = shreg;
        next_bit_cnt = bit_cnt;
        next_ptr     = ptr;
        next_sda_oe  = sda_oe;
        wr_en        = 1'b0;
        if (stop_ev) begin
            next_bus_st = lsrc_bus_idle;
            next_sda_oe = 1'b0;
        end else if (start_ev) begin
            next_bus_st  = lsrc_bus_dev;
            next_bit_cnt = 4'd0;
            next_sda_oe  = 1'b0;
        end else begin
            case (bus_st)
                lsrc_bus_dev, lsrc_bus_reg, lsrc_bus_wr: begin
                    if (scl_rise && bit_cnt < 4'd8) begin
                        next_shreg   = {shreg[6:0], sda_in};
                        next_bit_cnt = bit_cnt + 4'd1;
                    end else if (scl_fall && bit_cnt == 4'd8) begin
                        next_bit_cnt = 4'd0;
                        next_sda_oe  = 1'b1;
                        next_bus_st  = lsrc_bus_ack;
                        if (bus_st == lsrc_bus_dev) begin
                            next_ret_st = shreg[0] ? lsrc_bus_rd : lsrc_bus_reg;
                            if (shreg[7:1] != `LSRC_BUS_ADDR) begin
                                next_sda_oe = 1'b0;
                                next_bus_st = lsrc_bus_idle;
                            end
                        end else if (bus_st == lsrc_bus_reg) begin
                            next_ptr    = shreg;
                            next_ret_st = lsrc_bus_wr;
                        end else begin
                            // Burst writes advance the pointer after each byte
                            wr_en       = 1'b1;
                            next_ptr    = ptr_inc(ptr);
                            next_ret_st = lsrc_bus_wr;
                        end
                    end
                end
                lsrc_bus_ack: begin
                    if (scl_fall) begin
                        next_sda_oe  = 1'b0;
                        next_bus_st  = ret_st;
                        next_bit_cnt = 4'd0;
                        if (ret_st == lsrc_bus_rd) begin
                            next_shreg   = rd_mux(ptr);
                            next_sda_oe  = ~next_shreg[7];
                            next_bit_cnt = 4'd1;
                        end
                    end
                end
                lsrc_bus_rd: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'd8) begin
                            next_sda_oe = 1'b0;
                            next_bus_st = lsrc_bus_rack;
                        end else begin
                            next_sda_oe  = ~shreg[6];
                            next_shreg   = {shreg[6:0], 1'b0};
                            next_bit_cnt = bit_cnt + 4'd1;
                        end
                    end
                end
                lsrc_bus_rack: begin
                    // A missing acknowledge ends the burst
                    if (scl_rise && sda_in) begin
                        next_bus_st = lsrc_bus_idle;
                    end else if (scl_fall) begin
                        next_ptr     = ptr_inc(ptr);
                        next_shreg   = rd_mux(ptr_inc(ptr));
                        next_sda_oe  = ~next_shreg[7];
                        next_bit_cnt = 4'd1;
                        next_bus_st  = lsrc_bus_rd;
                    end
                end
                default: begin
                    next_bus_st = lsrc_bus_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            bus_st  <= lsrc_bus_idle;
            ret_st  <= lsrc_bus_idle;
            shreg   <= 8'h00;
            bit_cnt <= 4'd0;
            ptr     <= 8'h00;
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_q   <= scl_in;
            sda_q   <= sda_in;
            bus_st  <= next_bus_st;
            ret_st  <= next_ret_st;
            shreg   <= next_shreg;
            bit_cnt <= next_bit_cnt;
            ptr     <= next_ptr;
            sda_oe  <= next_sda_oe;
            sda_out <= 1'b0;  // Open drain only ever pulls low
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // The two result bytes are not latched together; a conversion between two
    // byte reads can tear the value, even in a burst read, which fetches each byte on its own acknowledge.
    always_comb begin
        next_mode          = mode;
        next_setup         = setup;
        next_result        = result;
        next_brownout_flag = brownout_flag;
        mode_wr            = 1'b0;
        setup_wr           = 1'b0;
        if (wr_en) begin
            if (ptr == `LSRC_OFS_OPCTL) begin
                next_mode = wr_data[`LSRC_MODE_MSB:`LSRC_MODE_LSB];
                mode_wr   = 1'b1;
            end else if (ptr == `LSRC_OFS_SETUP) begin
                next_setup = wr_data[`LSRC_RES_MSB:`LSRC_SCALE_LSB];
                setup_wr   = 1'b1;
            end else if (ptr == `LSRC_OFS_IDENT) begin
                // Only clearing is possible; power-up is the only setter
                if (!wr_data[`LSRC_BROWNOUT_FLAG_BIT]) begin
                    next_brownout_flag = 1'b0;
                end
            end
        end
        // Right-align by dropping the unresolved low bits
        if (conv.done && conv_st == lsrc_conv_run) begin
            next_result = (ir_chan ? adc_infrared_raw : adc_visible_raw)
                          >> (5'd16 - res_bits(setup[3:2]));
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode          <= `LSRC_OPCTL_RST;
            setup         <= `LSRC_SETUP_RST;
            result        <= `LSRC_RESULT_RST;
            brownout_flag <= `LSRC_BROWNOUT_FLAG_RST;
        end else begin
            mode          <= next_mode;
            setup         <= next_setup;
            result        <= next_result;
            brownout_flag <= next_brownout_flag;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    assign conv.res_sel = lsrc_res_t'(next_setup[3:2]);

    always_comb begin
        next_conv_st = conv_st;
        next_ir_chan = ir_chan;
        conv.start   = 1'b0;
        conv.abort   = 1'b0;
        if (mode_wr || setup_wr) begin
            // A mode write, or a setup write while converting, restarts with the new settings
            case (lsrc_mode_t'(next_mode))
                lsrc_mode_once_vis, lsrc_mode_cont_vis: begin
                    next_ir_chan = 1'b0;
                    next_conv_st = lsrc_conv_run;
                    conv.start   = 1'b1;
                end
                lsrc_mode_once_ir, lsrc_mode_cont_ir: begin
                    next_ir_chan = 1'b1;
                    next_conv_st = lsrc_conv_run;
                    conv.start   = 1'b1;
                end
                default: begin
                    // Reserved codes are treated as power-down
                    next_conv_st = lsrc_conv_off;
                    conv.abort   = 1'b1;
                end
            endcase
            // A setup write during a finished single shot waits for a mode write
            if (!mode_wr && conv_st != lsrc_conv_run) begin
                next_conv_st = conv_st;
                conv.start   = 1'b0;
                conv.abort   = 1'b0;
            end
        end else begin
            case (conv_st)
                lsrc_conv_run: begin
                    if (conv.done) begin
                        if (mode[2]) begin
                            conv.start = 1'b1;
                        end else begin
                            next_conv_st = lsrc_conv_hold;
                        end
                    end
                end
                default: begin
                    next_conv_st = conv_st;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conv_st              <= lsrc_conv_off;
            ir_chan              <= 1'b0;
            conv_active          <= 1'b0;
            infrared_select      <= 1'b0;
            full_scale_selection <= 2'b00;
            full_scale_lux       <= `LSRC_FS_LUX0;
        end else begin
            conv_st              <= next_conv_st;
            ir_chan              <= next_ir_chan;
            conv_active          <= (next_conv_st == lsrc_conv_run);
            infrared_select      <= next_ir_chan;
            full_scale_selection <= next_setup[`LSRC_SCALE_MSB:`LSRC_SCALE_LSB];
            case (next_setup[`LSRC_SCALE_MSB:`LSRC_SCALE_LSB])
                2'b00:   full_scale_lux <= `LSRC_FS_LUX0;
                2'b01:   full_scale_lux <= `LSRC_FS_LUX1;
                2'b10:   full_scale_lux <= `LSRC_FS_LUX2;
                default: full_scale_lux <= `LSRC_FS_LUX3;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Integration timer
    // ----------------------------------------------------------------
    lsrc_conv_timer #(
        .CYC_R16 (CYC_R16),
        .CYC_R12 (CYC_R12),
        .CYC_R8  (CYC_R8)
    ) u_timer (
        .clock (clock),
        .rst_n (rst_n),
        .conv  (conv.tmr)
    );

endmodule

/* File: tb/lsrc_monitor.sv */
// Port checker for the light sensor register control block
`timescale 1ns/100ps
module lsrc_monitor (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Serial bus
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_oe,
    // Converter side
    input wire logic        conv_active,
    input wire logic        infrared_select,
    input wire logic [1:0]  full_scale_selection,
    input wire logic [15:0] full_scale_lux
);
    // One domain, so clock and reset are given once
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Device only moves the data line while the serial clock is low
    AST_OE_LOWSCL: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved with serial clock high");
    AST_OE_RELEASE: assert property (sda_oe |-> ##[1:100] !sda_oe)
        else $error("data line held too long");
    AST_START_IDLE: assert property ($fell(sda_in) && scl_in && $past(scl_in) |=> !sda_oe)
        else $error("data line driven after start");
    AST_LUX_MAP: assert property (full_scale_lux == 16'd1000 << (2 * full_scale_selection))
        else $error("full scale lux mismatch");
    AST_RANGE_HOLD: assert property ($changed(full_scale_selection) |-> !scl_in)
        else $error("range changed outside a write");
    AST_CONV_START: assert property ($rose(conv_active) |-> !scl_in)
        else $error("conversion started outside a write");
    AST_IR_STABLE: assert property ($changed(infrared_select) |-> !scl_in)
        else $error("channel changed outside a write");
    AST_CONV_MIN: assert property ($rose(conv_active) |-> conv_active [*8])
        else $error("integration too short");
endmodule
bind lsrc_top lsrc_monitor u_lsrc_monitor (.clock(clock), .rst_n(rst_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_oe(sda_oe), .conv_active(conv_active), .infrared_select(infrared_select),
    .full_scale_selection(full_scale_selection), .full_scale_lux(full_scale_lux));

/* File: tb/lsrc_host_model.sv */
// Serial bus host model; released lines float to the pull-up level
`timescale 1ns/100ps
module lsrc_host_model (
    // Clock and resolved data line
    input  wire logic clock,
    input  wire logic sda_wire,
    // Driven lines
    output var  logic scl,
    output var  logic sda
);
    // Bus idle at time zero
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Half bit of four clocks, well over the two samples the device needs
    task automatic put(input logic c, input logic d);
        @(posedge clock);
        scl <= c;
        sda <= d;
        repeat (3) @(posedge clock);
    endtask
    // Start when s is high, stop when low; only the bus reaches registers
    task automatic cond(input logic s);
        put(1'b0, s);
        put(1'b1, s);
        put(1'b1, !s);
    endtask
    // Eight bits and the acknowledge slot, sampled half a clock before the high time ends
    task automatic xb(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            put(1'b0, d[i]);
            put(1'b1, d[i]);
            @(negedge clock) r[i] = sda_wire;
        end
    endtask
endmodule

/* File: tb/lsrc_tb_top.sv */
// Self-checking bench for the light sensor register control block
`timescale 1ns/100ps
module lsrc_tb_top;
    import lsrc_pkg::*;
    localparam logic [2:0] DEV      = 3'h2; // Arbitrary device code, the design's default
    localparam int         CYC [4]  = '{40, 30, 20, 2750};
    localparam logic [2:0] MODES [4] = '{3'b010, 3'b001, 3'b101, 3'b110};
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] vis   = 16'hbeef;
    logic [15:0] ir    = 16'h5a3c;
    logic        scl, hsda, sda_oe, sda_out, conv_active, ir_sel, nak;
    logic [1:0]  fss;
    logic [15:0] lux, e;
    logic [8:0]  r;
    wire         sda_w = hsda & !(sda_oe & !sda_out);
    int          error_cnt = 0;
    int          compares  = 0;
    always #4 clock = ~clock;
    lsrc_top #(.CYC_R16(40), .CYC_R12(30), .CYC_R8(20)) u_lsrc_top (.clock(clock),
        .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .adc_visible_raw(vis),
        .adc_infrared_raw(ir), .conv_active(conv_active), .infrared_select(ir_sel), .full_scale_selection(fss),
        .full_scale_lux(lux));
    lsrc_host_model u_lsrc_host_model (.clock(clock), .sda_wire(sda_w), .scl(scl), .sda(hsda));
    // Compare and bus tasks; every byte sent must be acknowledged
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sb(input logic [7:0] b);
        u_lsrc_host_model.xb({b, 1'b1}, r);
        nak |= r[0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        nak = 1'b0;
        u_lsrc_host_model.cond(1'b1);
        sb(8'h88);
        sb(a);
        sb(d);
        u_lsrc_host_model.cond(1'b0);
        chk({15'h0, nak}, 16'h0000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        nak = 1'b0;
        u_lsrc_host_model.cond(1'b1);
        sb(8'h88);
        sb(a);
        u_lsrc_host_model.cond(1'b1);
        sb(8'h89);
        u_lsrc_host_model.xb(9'h1ff, r);
        u_lsrc_host_model.cond(1'b0);
        chk({7'h0, nak, r[8:1] & m}, {8'h00, exp});
    endtask
    task automatic results();
        $display("mismatches %0d of %0d compares", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence: reset values, range codes, every mode and resolution, identity
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 4; i++) rd(8'(i), 8'h00, 8'hff);
        rd(8'h0f, {2'b10, DEV, 3'h0}, 8'hb8);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, {4'h3, 2'(i)});
            rd(8'h01, {4'h3, 2'(i)}, 8'h0f);
            chk(lux, 16'd1000 << (2 * i));
            chk({14'h0, fss}, 16'(i));
        end
        $display("range test done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, {4'h0, 2'(i), 2'b00});
            {vis, ir} <= {vis, ir} ^ 32'h1234_4321;
            wr(8'h00, {MODES[i], 5'h00});
            repeat (CYC[i] + 8) @(posedge clock);
            e = (MODES[i][1] ? ir : vis) >> (4 * i);
            rd(8'h02, e[7:0], 8'hff);
            rd(8'h03, e[15:8], 8'hff);
            chk({14'h0, ir_sel, conv_active}, {14'h0, MODES[i][1], MODES[i][2]});
        end
        ir <= ~ir;
        repeat (2800) @(posedge clock);
        rd(8'h02, {4'h0, ir[15:12]}, 8'hff);
        $display("conversion test done");
        wr(8'h0f, 8'h7f);
        wr(8'h0f, 8'hff);
        rd(8'h0f, {2'b00, DEV, 3'h0}, 8'hb8);
        wr(8'h03, 8'h55);
        rd(8'h03, e[15:8], 8'hff);
        rd(8'h07, 8'h00, 8'hff);
        wr(8'h00, 8'h00);
        chk({15'h0, conv_active}, 16'h0000);
        $display("identity test done");
        results();
    end
    // Watchdog, well beyond the expected run of some sixteen thousand clocks
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        results();
    end
endmodule
